//--- mivc_pkg.sv
// Constants and source numbering for the interrupt vectoring block
package mivc_pkg;
  // ==========================================================
  // Source indices, natural order first to last
  localparam int NUM_SRC = 13;
  localparam logic [3:0] SRC_AUX = 4'h0;
  localparam logic [3:0] SRC_EXT0 = 4'h1;
  localparam logic [3:0] SRC_TMR0 = 4'h2;
  localparam logic [3:0] SRC_EXT1 = 4'h3;
  localparam logic [3:0] SRC_TMR1 = 4'h4;
  localparam logic [3:0] SRC_SER0 = 4'h5;
  localparam logic [3:0] SRC_TMR2 = 4'h6;
  localparam logic [3:0] SRC_SER1 = 4'h7;
  localparam logic [3:0] SRC_EXT2 = 4'h8;
  localparam logic [3:0] SRC_WDOG = 4'hC;
  // ==========================================================
  // Vector addresses
  localparam logic [7:0] VEC_AUX = 8'h33;
  localparam logic [7:0] VEC_EXT0 = 8'h03;
  localparam logic [7:0] VEC_TMR0 = 8'h0B;
  localparam logic [7:0] VEC_EXT1 = 8'h13;
  localparam logic [7:0] VEC_TMR1 = 8'h1B;
  localparam logic [7:0] VEC_SER0 = 8'h23;
  localparam logic [7:0] VEC_TMR2 = 8'h2B;
  localparam logic [7:0] VEC_SER1 = 8'h3B;
  localparam logic [7:0] VEC_EXT2 = 8'h43;
  localparam logic [7:0] VEC_STEP = 8'h08;
  localparam logic [7:0] VEC_WDOG = 8'h63;
  // ==========================================================
  // Priority levels and reset values
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_HIGH = 2'h1;
  localparam logic [1:0] LVL_AUX = 2'h2;
  localparam logic [7:0] AUX_ENABLE_RST = 8'h00;
  localparam logic [7:0] VEC_RST = 8'h00;
endpackage : mivc_pkg

//--- mivc_irq_ctrl.sv
// Interrupt flag, enable, priority and vector logic for the 8051 core
`timescale 1ns/100ps

// Operation
// RL1 - Three levels; each source own flag, enable, vector; aux group on top
// RL2 - Digital supply low and breakpoint vector to 33h, enabled by own bits
// RL3 - Analog supply low is aux source bit 1
// RL4 - SPI receive or two-wire event is aux source bit 2
// RL5 - SPI transmit is aux source bit 3, shares aux vector
// RL6 - Millisecond tick is aux source bit 4
// RL7 - Conversion done is aux source bit 5
// RL8 - Accumulator event is aux source bit 6
// RL9 - Second tick is aux source bit 7
// RL10 - Enabled aux event sets group pending; group enable gates vectoring
// RL11 - Select 1: poll view shows raw events, enable view shows contents
// RL12 - Read select 0: the two views swap
// RL13 - Edge external flags clear in hardware when their vector is taken
// RL14 - Level external 0 and 1 flags follow the pin
// RL15 - Timer 0 and 1 overflow flags clear when their vector is taken
// RL16 - Standard sources also need the global enable
// RL17 - Standard sources use the fixed vector table
// RL18 - Same level ties resolve in natural order, aux first, watchdog last
module mivc_irq_ctrl import mivc_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic digital_supply_low_event,
  input wire logic breakpoint_event,
  input wire logic breakpoint_irq_enable,
  input wire logic analog_supply_low_event,
  input wire logic spi_receive_event,
  input wire logic two_wire_event,
  input wire logic spi_transmit_event,
  input wire logic millisecond_tick_event,
  input wire logic conversion_done_event,
  input wire logic accumulator_event,
  input wire logic second_tick_event,
  input wire logic aux_enable_we,
  input wire logic [7:0] aux_enable_wdata,
  input wire logic aux_read_select,
  input wire logic aux_group_enable,
  input wire logic aux_pending_clear,
  input wire logic global_irq_enable,
  input wire logic [5:0] ext_pin_n,
  input wire logic [1:0] ext_edge_mode,
  input wire logic [5:0] ext_flag_clear,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic [1:0] timer_flag_clear,
  input wire logic timer2_overflow_flag,
  input wire logic serial0_flag,
  input wire logic serial1_flag,
  input wire logic watchdog_pending,
  input wire logic [12:1] std_irq_enable,
  input wire logic [12:1] std_priority,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [7:0] irq_vector,
  output logic [1:0] irq_level,
  output logic [7:0] aux_poll_read,
  output logic [7:0] aux_enable_read,
  output logic aux_group_pending,
  output logic [5:0] ext_pending,
  output logic [1:0] timer_flags
);
  // ==========================================================
  // Reset release
  logic rst_s1_reg;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [7:0] vec_of(input logic [3:0] src);
    logic [7:0] v;
    v = VEC_WDOG;
    case (src)
      SRC_AUX: v = VEC_AUX;
      SRC_EXT0: v = VEC_EXT0;
      SRC_TMR0: v = VEC_TMR0;
      SRC_EXT1: v = VEC_EXT1;
      SRC_TMR1: v = VEC_TMR1;
      SRC_SER0: v = VEC_SER0;
      SRC_TMR2: v = VEC_TMR2;
      SRC_SER1: v = VEC_SER1;
      4'h8, 4'h9, 4'hA, 4'hB: v = VEC_EXT2 + VEC_STEP * {6'h00, src[1:0]};
      default: v = VEC_WDOG;
    endcase
    return v; // RL17
  endfunction : vec_of

  // ==========================================================
  // Aux group
  logic [7:0] aux_enable_reg, aux_enable_next;
  logic aux_pend_reg, aux_pend_next;
  logic [7:0] aux_raw, aux_masked;
  logic [7:0] poll_rd_reg, poll_rd_next, en_rd_reg, en_rd_next;

  always_comb begin
    aux_raw = {second_tick_event, accumulator_event, conversion_done_event,
               millisecond_tick_event, spi_transmit_event,
               spi_receive_event | two_wire_event, analog_supply_low_event,
               digital_supply_low_event | breakpoint_event};
    // Bit 0 carries two events, each gated by its own enable
    aux_masked = aux_raw & aux_enable_reg; // RL3 RL4 RL5 RL6 RL7 RL8 RL9
    aux_masked[0] = (digital_supply_low_event & aux_enable_reg[0]) |
                    (breakpoint_event & breakpoint_irq_enable); // RL2
    aux_enable_next = aux_enable_we ? aux_enable_wdata : aux_enable_reg;
    // Set wins over a clear in the same cycle
    aux_pend_next = (|aux_masked) |
                    (aux_pend_reg & ~aux_pending_clear); // RL10
    poll_rd_next = aux_read_select ? aux_raw : aux_enable_reg; // RL11 RL12
    en_rd_next = aux_read_select ? aux_enable_reg : aux_raw; // RL11 RL12
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_enable_reg <= AUX_ENABLE_RST;
      aux_pend_reg <= 1'b0;
      poll_rd_reg <= 8'h00;
      en_rd_reg <= 8'h00;
    end else begin
      aux_enable_reg <= aux_enable_next;
      aux_pend_reg <= aux_pend_next;
      poll_rd_reg <= poll_rd_next;
      en_rd_reg <= en_rd_next;
    end
  end

  // ==========================================================
  // Standard flags
  logic [5:0] pin_prev_reg, ext_flag_reg, ext_flag_next, ext_fall;
  logic [1:0] tmr_flag_reg, tmr_flag_next;
  logic ack_take;
  logic [3:0] src_reg;

  always_comb begin
    ack_take = irq_ack & irq_req;
    ext_fall = pin_prev_reg & ~ext_pin_n;
    for (int i = 0; i < 6; i++) begin
      ext_flag_next[i] = ext_flag_reg[i] & ~ext_flag_clear[i];
    end
    if (ack_take && src_reg == SRC_EXT0) ext_flag_next[0] = 1'b0; // RL13
    if (ack_take && src_reg == SRC_EXT1) ext_flag_next[1] = 1'b0; // RL13
    for (int i = 2; i < 6; i++) begin
      if (ack_take && src_reg == SRC_EXT2 + 4'(i - 2)) begin
        ext_flag_next[i] = 1'b0; // RL13
      end
    end
    // A new edge wins over any clear
    ext_flag_next = ext_flag_next | ext_fall;
    for (int i = 0; i < 2; i++) begin
      if (!ext_edge_mode[i]) ext_flag_next[i] = ~ext_pin_n[i]; // RL14
    end
    tmr_flag_next = tmr_flag_reg & ~timer_flag_clear;
    if (ack_take && src_reg == SRC_TMR0) tmr_flag_next[0] = 1'b0; // RL15
    if (ack_take && src_reg == SRC_TMR1) tmr_flag_next[1] = 1'b0; // RL15
    tmr_flag_next = tmr_flag_next | {timer1_overflow, timer0_overflow};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_reg <= 6'h3F;
      ext_flag_reg <= 6'h00;
      tmr_flag_reg <= 2'h0;
    end else begin
      pin_prev_reg <= ext_pin_n;
      ext_flag_reg <= ext_flag_next;
      tmr_flag_reg <= tmr_flag_next;
    end
  end

  // ==========================================================
  // Arbitration
  logic [12:0] pend, req;
  logic [1:0] lvl [13];
  logic found;
  logic [3:0] win_src;
  logic [1:0] win_lvl;
  logic req_reg, req_next;
  logic [3:0] src_next;
  logic [7:0] vec_reg, vec_next;
  logic [1:0] lvl_reg, lvl_next;

  always_comb begin
    pend = {watchdog_pending, ext_flag_reg[5:2], serial1_flag,
            timer2_overflow_flag, serial0_flag, tmr_flag_reg[1],
            ext_flag_reg[1], tmr_flag_reg[0], ext_flag_reg[0], aux_pend_reg};
    req[0] = pend[0] & aux_group_enable; // RL10
    req[12:1] = pend[12:1] & std_irq_enable & {12{global_irq_enable}}; // RL16
    lvl[0] = LVL_AUX; // RL1
    for (int i = 1; i < NUM_SRC; i++) begin
      lvl[i] = std_priority[i] ? LVL_HIGH : LVL_LOW; // RL1
    end
    found = 1'b0;
    win_src = SRC_AUX;
    win_lvl = LVL_LOW;
    // Lower index wins a tie: strict compare keeps the earlier one
    for (int i = 0; i < NUM_SRC; i++) begin
      if (req[i] && (!found || lvl[i] > win_lvl)) begin // RL18
        found = 1'b1;
        win_src = 4'(i);
        win_lvl = lvl[i];
      end
    end
    // Drop the request for one cycle after an ack so cleared flags settle
    req_next = found & ~ack_take;
    src_next = win_src;
    vec_next = found ? vec_of(win_src) : VEC_RST;
    lvl_next = win_lvl;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_reg <= 1'b0;
      src_reg <= SRC_AUX;
      vec_reg <= VEC_RST;
      lvl_reg <= LVL_LOW;
    end else begin
      req_reg <= req_next;
      src_reg <= src_next;
      vec_reg <= vec_next;
      lvl_reg <= lvl_next;
    end
  end

  assign irq_req = req_reg;
  assign irq_vector = vec_reg;
  assign irq_level = lvl_reg;
  assign aux_poll_read = poll_rd_reg;
  assign aux_enable_read = en_rd_reg;
  assign aux_group_pending = aux_pend_reg;
  assign ext_pending = ext_flag_reg;
  assign timer_flags = tmr_flag_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  aux_level_top_a: assert property ( // RL1
    req_reg && src_reg == SRC_AUX |->
    lvl_reg == LVL_AUX && vec_reg == VEC_AUX)
    else $error("aux request not at top level or 33h");
  aux_bp_vec_a: assert property ( // RL2
    (breakpoint_event && breakpoint_irq_enable && aux_group_enable) ##1
    (aux_group_enable && !ack_take) |=> req_reg && lvl_reg == LVL_AUX)
    else $error("breakpoint did not raise aux request");
  aux_pend_set_a: assert property (|aux_masked |=> aux_pend_reg) // RL10
    else $error("aux pending not set");
  poll_raw_a: assert property ( // RL11
    aux_read_select |=> poll_rd_reg == $past(aux_raw) &&
    en_rd_reg == $past(aux_enable_reg))
    else $error("raw view wrong with select high");
  poll_swap_a: assert property ( // RL12
    !aux_read_select |=> en_rd_reg == $past(aux_raw) &&
    poll_rd_reg == $past(aux_enable_reg))
    else $error("swapped view wrong with select low");
  ext_edge_clr_a: assert property ( // RL13
    ack_take && src_reg == SRC_EXT2 && !ext_fall[2] |=> !ext_flag_reg[2])
    else $error("edge flag not cleared on vector");
  ext_level_a: assert property ( // RL14
    !ext_edge_mode[0] |=> ext_flag_reg[0] == !$past(ext_pin_n[0]))
    else $error("level flag does not follow pin");
  tmr_clr_a: assert property ( // RL15
    ack_take && src_reg == SRC_TMR0 && !timer0_overflow |=> !tmr_flag_reg[0])
    else $error("timer 0 flag not cleared on vector");
  global_gate_a: assert property ( // RL16
    req_reg && src_reg != SRC_AUX |-> $past(global_irq_enable))
    else $error("standard vector without global enable");
  ext0_vec_a: assert property ( // RL17
    req_reg && src_reg == SRC_EXT0 |-> vec_reg == VEC_EXT0)
    else $error("external 0 vector wrong");
  // Only a tie at the winning level must go to the lower index
  order_a: assert property ( // RL18
    req[1] && req[2] && lvl[1] == lvl[2] && win_lvl == lvl[1] |=>
    src_reg == SRC_EXT0)
    else $error("tie not resolved in natural order");

  aux_taken_c: cover property (req_reg && src_reg == SRC_AUX ##1 irq_ack);
  high_pre_c: cover property (req_reg && lvl_reg == LVL_HIGH &&
    src_reg == SRC_WDOG);
  ext_ack_c: cover property (ack_take && src_reg == SRC_EXT1);
  select_flip_c: cover property (aux_read_select ##1 !aux_read_select);
endmodule : mivc_irq_ctrl

//--- mivc_core_model.sv
// Core model that takes vectors after a chosen wait
`timescale 1ns/100ps
module mivc_core_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic irq_req,
  input wire logic [1:0] delay,
  output logic irq_ack
);
  // ==========================================================
  // Acknowledge
  logic [1:0] waited;
  // One-cycle ack, only while a request stands; re-arms after a gap
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_ack <= 1'b0;
      waited <= 2'h0;
    end else if (irq_ack || !irq_req) begin
      irq_ack <= 1'b0;
      waited <= 2'h0;
    end else if (waited == delay) begin
      irq_ack <= 1'b1;
    end else begin
      waited <= waited + 2'h1;
    end
  end
endmodule : mivc_core_model

//--- test_mcu_interrupt_vectoring.sv
// Self-checking bench for the interrupt vectoring block
`timescale 1ns/100ps
module test_mcu_interrupt_vectoring import mivc_pkg::*; ;
  // ==========================================================
  // Signals
  logic clk = 1'b0;
  logic resetn, breakpoint_irq_enable, aux_enable_we, aux_read_select;
  logic aux_group_enable, aux_pending_clear, global_irq_enable, irq_ack;
  logic timer0_overflow, timer1_overflow, timer2_overflow_flag;
  logic serial0_flag, serial1_flag, watchdog_pending, irq_req;
  logic digital_supply_low_event, analog_supply_low_event;
  logic spi_receive_event, spi_transmit_event, millisecond_tick_event;
  logic conversion_done_event, accumulator_event, second_tick_event;
  logic two_wire_event, breakpoint_event, aux_group_pending;
  logic [7:0] aux_enable_wdata, irq_vector, aux_poll_read, aux_enable_read;
  logic [5:0] ext_pin_n, ext_flag_clear, ext_pending;
  logic [1:0] ext_edge_mode, timer_flag_clear, irq_level, timer_flags, delay;
  logic [12:1] std_irq_enable, std_priority;
  logic [9:0] aux_ev;
  logic [31:0] rnd = 32'h00015A39;
  logic [7:0] en;
  logic [7:0] vt [13] = '{8'h33, 8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23,
    8'h2B, 8'h3B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63};
  int exp_q[$];
  int failures = 0;
  int comparisons = 0;
  int b;
  assign {breakpoint_event, two_wire_event, second_tick_event,
    accumulator_event, conversion_done_event, millisecond_tick_event,
    spi_transmit_event, spi_receive_event, analog_supply_low_event,
    digital_supply_low_event} = aux_ev;
  always #5 clk = ~clk;
  mivc_irq_ctrl mivc_irq_ctrl_inst (.*);
  mivc_core_model mivc_core_model_inst (.clk(clk), .resetn(resetn),
    .irq_req(irq_req), .delay(delay), .irq_ack(irq_ack));
  // ==========================================================
  // Tasks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input string name, input logic [15:0] seen,
    input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] v);
    aux_enable_we = 1'b1;
    aux_enable_wdata = v;
    tick(1);
    aux_enable_we = 1'b0;
  endtask : wr
  task automatic fire(input int i, input logic v);
    case (i)
      1, 3: ext_pin_n[i/2] = !v;
      8, 9, 10, 11: ext_pin_n[i-6] = !v;
      2: timer0_overflow = v;
      4: timer1_overflow = v;
      5: serial0_flag = v;
      6: timer2_overflow_flag = v;
      7: serial1_flag = v;
      default: watchdog_pending = v;
    endcase
  endtask : fire
  // Model: queue of expected sources, vector and level from the rules
  task automatic take();
    int s;
    int n;
    s = exp_q.pop_front();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (irq_ack !== 1'b1 && n < 40);
    check("ack", irq_ack, 1);
    check("vector", irq_vector, vt[s]);
    check("level", irq_level, (s == 0) ? LVL_AUX : std_priority[s]);
    tick(1);
  endtask : take
  task automatic complete_run();
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // ==========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run();
  end
  // ==========================================================
  // Sequence
  initial begin
    {resetn, breakpoint_irq_enable, aux_enable_we, aux_read_select} = '0;
    {aux_group_enable, aux_pending_clear, global_irq_enable} = '0;
    {timer0_overflow, timer1_overflow, timer2_overflow_flag} = '0;
    {serial0_flag, serial1_flag, watchdog_pending} = '0;
    {aux_enable_wdata, aux_ev, ext_flag_clear, timer_flag_clear} = '0;
    {std_irq_enable, std_priority, delay} = '0;
    ext_pin_n = 6'h3F;
    ext_edge_mode = 2'h3;
    tick(12);
    resetn = 1'b1;
    tick(4);
    check("reset", {irq_req, irq_vector}, {1'b0, VEC_RST});
    check("reset views", {aux_poll_read, aux_enable_read}, 16'h0000);
    for (int k = 0; k < 10; k++) begin
      b = (k == 8) ? 2 : (k == 9) ? 0 : k;
      rnd = lfsr(rnd);
      en = rnd[7:0] & ~(8'h01 << b);
      wr(en);
      aux_group_enable = 1'b1;
      aux_ev[k] = 1'b1;
      aux_read_select = 1'b1;
      tick(3);
      check("pending", aux_group_pending, 0);
      check("enable view", aux_enable_read, en);
      if (k < 9) check("poll view", aux_poll_read, 8'h01 << b);
      aux_read_select = 1'b0;
      tick(2);
      check("poll view", aux_poll_read, en);
      if (k < 9) check("enable view", aux_enable_read, 8'h01 << b);
      breakpoint_irq_enable = (k == 9);
      wr((k == 9) ? en : en | (8'h01 << b));
      exp_q.push_back(0);
      take();
      check("pending", aux_group_pending, 1);
      aux_ev = '0;
      aux_group_enable = 1'b0;
      aux_pending_clear = 1'b1;
      tick(1);
      aux_pending_clear = 1'b0;
      tick(1);
      check("pending", aux_group_pending, 0);
    end
    breakpoint_irq_enable = 1'b0;
    for (int i = 1; i < 13; i++) begin
      rnd = lfsr(rnd);
      delay = rnd[13:12];
      std_priority = rnd[11:0];
      std_irq_enable = '0;
      std_irq_enable[i] = 1'b1;
      global_irq_enable = 1'b0;
      fire(i, 1'b1);
      tick(1);
      {timer0_overflow, timer1_overflow} = 2'h0;
      tick(3);
      check("request", irq_req, 0);
      global_irq_enable = 1'b1;
      exp_q.push_back(i);
      take();
      fire(i, 1'b0);
      tick(2);
      check("flags", {ext_pending, timer_flags}, 0);
      check("request", irq_req, 0);
    end
    // Same level goes by natural order; the high level goes first
    std_priority = 12'h004;
    std_irq_enable = 12'h007;
    ext_pin_n = 6'h3C;
    timer0_overflow = 1'b1;
    tick(1);
    timer0_overflow = 1'b0;
    exp_q = '{3, 1, 2};
    take();
    take();
    take();
    ext_pin_n = 6'h3F;
    std_irq_enable = '0;
    tick(1);
    ext_edge_mode = 2'h0;
    ext_pin_n = 6'h3E;
    tick(2);
    check("level flag", ext_pending[1:0], 2'h1);
    ext_pin_n = 6'h3D;
    tick(2);
    check("level flag", ext_pending[1:0], 2'h2);
    ext_pin_n = 6'h37;
    timer1_overflow = 1'b1;
    tick(1);
    timer1_overflow = 1'b0;
    tick(2);
    check("flags", {ext_pending, timer_flags}, 8'h22);
    ext_flag_clear = 6'h08;
    timer_flag_clear = 2'h2;
    tick(1);
    {ext_flag_clear, timer_flag_clear} = '0;
    tick(1);
    check("flags", {ext_pending, timer_flags}, 0);
    complete_run();
  end
endmodule : test_mcu_interrupt_vectoring
